/* logic/tac_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - battery switch high only on matching enabled measurement
// - sequence: idle, per-measurement fetch settle convert, end
// - conversion is one fetch plus sixteen cycles
// - five interrupt sources merge into one request
// - masks gate requests, never clear latched status
// - brownout latched until its clear bit written
// - dedicated brownout output and raw status bit
// - brownout may relatch right after clear
// - touch latched until cleared, raw level visible
// - touch event may start a sequence
// - touch latches only on edges, not levels
// - end of sequence latched until cleared
// - watermark follows fifo count against threshold
// - overrun on write to full fifo, cleared by read
// - registers and banks at fixed word offsets
// - registers are little endian words
// - active high word mirrors current bank entry
// - settle field sets settling ticks before conversion
// - positive input field drives converter input mux
// - negative input bit selects ground or reference
// - power modes off force brownout and stop clock
module tac_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire tac_pkg::tac_apb_req_t apb_req,
  output tac_pkg::tac_apb_rsp_t apb_rsp,
  input wire logic [tac_pkg::ADC_W-1:0] conv_result,
  input wire logic brownout_det,
  input wire logic touch_detect_irq,
  output tac_pkg::tac_hw_t active_cfg_high,
  output logic [31:0] active_cfg_low,
  output logic battery_switch_out,
  output logic combined_irq,
  output logic brownout_irq
);
  import tac_pkg::*;

  tac_regs_t s;
  tac_regs_t next_s;

  logic tick;
  logic pwr_on;
  logic bo_raw;
  logic setup;
  logic access;
  logic wr;
  logic rd_pop;
  logic push;
  logic do_push;
  logic do_pop;
  logic touch_edge;
  logic trig;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] set;
  logic [3:0] conv_count;
  logic [15:0] res_word;

  function automatic logic [3:0] bank_idx(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[5:2];
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] div_last(input logic [2:0] sel);
    return 8'((9'h001 << sel) - 9'h001);
  endfunction

  function automatic logic measuring(input tac_seq_t st);
    return (st == TAC_FETCH) || (st == TAC_SETTLE) || (st == TAC_MEASURE);
  endfunction

  always_comb begin
    next_s = s;
    tick = 1'b0;
    push = 1'b0;
    clr = '0;
    set = '0;
    res_word = '0;
    conv_count = s.pc[PC_NOC_LO +: 4];
    // off modes stop the converter clock and report brownout
    pwr_on = (s.pc[PC_PWM_LO +: 2] == PWM_STANDBY) ||
             (s.pc[PC_PWM_LO +: 2] == PWM_RUN);
    bo_raw = brownout_det | ~pwr_on;
    touch_edge = touch_detect_irq & ~s.touch_q;
    next_s.touch_q = touch_detect_irq;
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    wr = access & apb_req.pwrite & ~s.rsp.pslverr;
    rd_pop = access & ~apb_req.pwrite & (apb_req.paddr == OFS_RR);
    next_s.rsp.pready = 1'b1;

    // converter clock prescaler, divide by two to the select
    if (!pwr_on) begin
      next_s.pre = '0;
    end else if (s.pre >= div_last(s.pc[PC_CLK_LO +: 3])) begin
      next_s.pre = '0;
      tick = 1'b1;
    end else begin
      next_s.pre = s.pre + 8'h01;
    end

    // read data is fetched in the setup phase, shown in the access phase
    if (setup) begin
      next_s.rsp.pslverr = 1'b0;
      next_s.rsp.prdata = '0;
      if (apb_req.paddr[1:0] != 2'h0) begin
        next_s.rsp.pslverr = 1'b1;
      end else if (in_range(apb_req.paddr, OFS_BHI, OFS_BHI_END)) begin
        next_s.rsp.prdata = s.bhi[bank_idx(apb_req.paddr, OFS_BHI)];
      end else if (in_range(apb_req.paddr, OFS_BLO, OFS_BLO_END)) begin
        next_s.rsp.prdata = s.blo[bank_idx(apb_req.paddr, OFS_BLO)];
      end else begin
        unique case (apb_req.paddr)
          OFS_HW: next_s.rsp.prdata = s.hw;
          OFS_LW: next_s.rsp.prdata = s.lw;
          OFS_RR: next_s.rsp.prdata = 32'(s.fifo[s.rp]);
          OFS_IM: next_s.rsp.prdata = s.im;
          OFS_PC: next_s.rsp.prdata = s.pc;
          OFS_GC: next_s.rsp.prdata = s.gc;
          OFS_GS: begin
            next_s.rsp.prdata[GS_BO_RAW] = bo_raw;
            next_s.rsp.prdata[GS_TOUCH_RAW] = touch_detect_irq;
            next_s.rsp.prdata[GS_BUSY] = s.st != TAC_IDLE;
            next_s.rsp.prdata[GS_STATE_LO +: 3] = s.st;
            next_s.rsp.prdata[3:0] = s.idx;
          end
          OFS_IS: next_s.rsp.prdata = 32'(s.is);
          OFS_FS: begin
            next_s.rsp.prdata[FS_RP_LO +: 4] = s.rp;
            next_s.rsp.prdata[FS_WP_LO +: 4] = s.wp;
            next_s.rsp.prdata[FS_EMPTY] = s.fcnt == 5'h00;
            next_s.rsp.prdata[FS_FULL] = s.fcnt == FIFO_DEPTH;
            next_s.rsp.prdata[FS_CNT_LO +: 5] = s.fcnt;
          end
          OFS_IHW: next_s.rsp.prdata = s.ihw;
          OFS_ILW: next_s.rsp.prdata = s.ilw;
          OFS_MIS: next_s.rsp.prdata = 32'(s.is & s.im[IRQ_W-1:0]);
          OFS_IC: next_s.rsp.prdata = '0;
          default: next_s.rsp.pslverr = 1'b1;
        endcase
      end
    end

    // writes land in the access phase; byte 0 is bits 7:0
    if (wr) begin
      if (in_range(apb_req.paddr, OFS_BHI, OFS_BHI_END)) begin
        next_s.bhi[bank_idx(apb_req.paddr, OFS_BHI)] = apb_req.pwdata;
      end else if (in_range(apb_req.paddr, OFS_BLO, OFS_BLO_END)) begin
        next_s.blo[bank_idx(apb_req.paddr, OFS_BLO)] = apb_req.pwdata;
      end else begin
        unique case (apb_req.paddr)
          OFS_IM: next_s.im = {25'h0, apb_req.pwdata[IM_GLOBAL:0]};
          OFS_PC: next_s.pc = {17'h0, apb_req.pwdata[14:0]};
          OFS_GC: next_s.gc = {25'h0, apb_req.pwdata[6:0]};
          OFS_IHW: next_s.ihw = apb_req.pwdata;
          OFS_ILW: next_s.ilw = apb_req.pwdata;
          OFS_IC: clr = apb_req.pwdata[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
    // the start bit is a strobe; it never reads back as set
    next_s.gc[GC_SW_START] = 1'b0;

    // a trigger stays pending until the idle tick consumes it
    trig = (wr && apb_req.paddr == OFS_GC && apb_req.pwdata[GC_SW_START]) ||
           (touch_edge && s.gc[GC_TOUCH_TRIG]);
    if (trig) begin
      next_s.pend = 1'b1;
    end

    // sequencer advances only on converter clock ticks
    if (tick) begin
      unique case (s.st)
        TAC_IDLE: begin
          if (s.pend) begin
            next_s.pend = trig; // set wins over consume
            next_s.idx = '0;
            next_s.st = TAC_FETCH;
            next_s.hw = s.bhi[4'h0];
            next_s.lw = s.blo[4'h0];
          end
        end
        TAC_FETCH: begin
          next_s.cnt = '0;
          if (s.hw.settle_cycles == 9'h000) begin
            next_s.st = TAC_MEASURE;
          end else begin
            next_s.st = TAC_SETTLE;
          end
        end
        TAC_SETTLE: begin
          // the input settles for exactly settle_cycles ticks
          if (s.cnt + 9'h001 >= s.hw.settle_cycles) begin
            next_s.cnt = '0;
            next_s.st = TAC_MEASURE;
          end else begin
            next_s.cnt = s.cnt + 9'h001;
          end
        end
        TAC_MEASURE: begin
          if (s.cnt == MEAS_LAST) begin
            push = 1'b1;
            res_word[RR_DATA_LO +: ADC_W] = conv_result;
            res_word[3:0] = s.idx;
            next_s.cnt = '0;
            if (s.idx == conv_count) begin
              next_s.st = TAC_EOS;
            end else begin
              next_s.idx = s.idx + 4'h1;
              next_s.st = TAC_FETCH;
              next_s.hw = s.bhi[s.idx + 4'h1];
              next_s.lw = s.blo[s.idx + 4'h1];
            end
          end else begin
            next_s.cnt = s.cnt + 9'h001;
          end
        end
        TAC_EOS: begin
          set[IRQ_EOS] = 1'b1;
          next_s.st = TAC_IDLE;
          next_s.hw = s.ihw;
          next_s.lw = s.ilw;
          if (s.gc[GC_REPEAT]) begin
            next_s.pend = 1'b1;
          end
        end
        default: next_s.st = TAC_IDLE;
      endcase
    end

    // result fifo; a write into a full fifo is dropped and flagged
    do_push = push && (s.fcnt != FIFO_DEPTH);
    do_pop = rd_pop && (s.fcnt != 5'h00);
    set[IRQ_OVR] = push && (s.fcnt == FIFO_DEPTH);
    if (do_push) begin
      next_s.fifo[s.wp] = res_word;
      next_s.wp = s.wp + 4'h1;
    end
    if (do_pop) begin
      next_s.rp = s.rp + 4'h1;
    end
    next_s.fcnt = 5'(s.fcnt + {4'h0, do_push} - {4'h0, do_pop});

    // latched status: a set in the clearing cycle wins
    set[IRQ_BO] = bo_raw;
    set[IRQ_TOUCH] = touch_edge;
    clr[IRQ_OVR] = clr[IRQ_OVR] | rd_pop;
    next_s.is = (s.is & ~clr) | set;
    // watermark is a level, not latched
    next_s.is[IRQ_WM] = next_s.fcnt >=
                        {1'b0, next_s.gc[GC_WMK_LO +: 4]};

    // mask only gates the request; brownout also has its own line
    next_s.comb = next_s.im[IM_GLOBAL] &&
                  |(next_s.is & next_s.im[IRQ_W-1:0]);

    // switch only while the enabled channel is being measured
    next_s.batt = next_s.pc[PC_BATTERY_ENABLE] && measuring(next_s.st) &&
                  (next_s.hw.pos_input_sel ==
                   next_s.pc[PC_BATTERY_CHANNEL_SEL_LO +: 4]);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp = s.rsp;
  assign active_cfg_high = s.hw;
  assign active_cfg_low = s.lw;
  assign battery_switch_out = s.batt;
  assign combined_irq = s.comb;
  assign brownout_irq = s.is[IRQ_BO];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_batt_switch_match: assert property (
    battery_switch_out |-> s.pc[PC_BATTERY_ENABLE] && measuring(s.st) &&
      s.hw.pos_input_sel == s.pc[PC_BATTERY_CHANNEL_SEL_LO +: 4])
    else $error("battery switch high without matching measurement");

  a_fetch_one_tick: assert property (
    (s.st == TAC_FETCH && tick) |=> s.st inside {TAC_SETTLE, TAC_MEASURE})
    else $error("fetch state lasted more than one tick");

  a_measure_sixteen: assert property (
    (s.st == TAC_MEASURE && tick && s.cnt == MEAS_LAST) |=>
      s.st inside {TAC_FETCH, TAC_EOS} && s.cnt == 9'h000)
    else $error("measurement did not end after sixteen ticks");

  a_eos_latched: assert property (
    (s.st == TAC_EOS && tick) |=> s.is[IRQ_EOS] && s.st == TAC_IDLE)
    else $error("end of sequence status not raised");

  a_bo_hold: assert property (
    (s.is[IRQ_BO] && !(wr && apb_req.paddr == OFS_IC &&
      apb_req.pwdata[IRQ_BO])) |=> s.is[IRQ_BO])
    else $error("brownout status dropped without clear");

  a_bo_forced_off: assert property (
    (s.pc[PC_PWM_LO +: 2] == 2'h0) |=> s.is[IRQ_BO] ##1 brownout_irq)
    else $error("off power mode did not force brownout");

  a_comb_request: assert property (
    combined_irq == (s.im[IM_GLOBAL] && |(s.is & s.im[IRQ_W-1:0])))
    else $error("combined request does not match enabled status");

  a_wm_level: assert property (
    !$past(sys_rst) |->
      s.is[IRQ_WM] == (s.fcnt >= {1'b0, s.gc[GC_WMK_LO +: 4]}))
    else $error("watermark status disagrees with fifo count");

  a_ovr_on_full: assert property (
    (push && s.fcnt == FIFO_DEPTH && !rd_pop) |=>
      s.is[IRQ_OVR] && s.fcnt == FIFO_DEPTH)
    else $error("overrun not flagged on full fifo write");

  a_hi_mirror: assert property (
    (s.st == TAC_MEASURE && tick && s.cnt == MEAS_LAST && s.idx != conv_count)
      |=> s.hw == s.bhi[$past(s.idx) + 4'h1])
    else $error("active high word does not mirror bank entry");

  a_start_fetch: assert property (
    (s.st == TAC_IDLE && tick && s.pend) |=>
      s.st == TAC_FETCH && s.idx == 4'h0)
    else $error("pending trigger did not start a sequence");

  a_settle_hold: assert property (
    (s.st == TAC_SETTLE && tick && s.cnt + 9'h001 < s.hw.settle_cycles)
      |=> s.st == TAC_SETTLE && s.cnt == $past(s.cnt) + 9'h001)
    else $error("settling ended before its programmed count");

  a_settle_end: assert property (
    (s.st == TAC_SETTLE && tick && s.cnt + 9'h001 >= s.hw.settle_cycles)
      |=> s.st == TAC_MEASURE && s.cnt == 9'h000)
    else $error("settling overran its programmed count");

  a_idle_restore: assert property (
    (s.st == TAC_EOS && tick) |=> s.hw == $past(s.ihw))
    else $error("idle word not restored after end of sequence");

  a_off_frozen: assert property (
    !pwr_on |=> s.st == $past(s.st) && s.pre == '0)
    else $error("converter clock ran in an off power mode");

  a_ovr_clear: assert property (
    (rd_pop && !(push && s.fcnt == FIFO_DEPTH)) |=> !s.is[IRQ_OVR])
    else $error("overrun status survived a result read");

  a_touch_latch: assert property (
    (touch_detect_irq && !s.touch_q) |=> s.is[IRQ_TOUCH])
    else $error("touch edge was not latched");

  c_seq_done: cover property (s.st == TAC_EOS ##1 s.st == TAC_IDLE);
  c_overrun: cover property ($rose(s.is[IRQ_OVR]));
  c_touch_start: cover property (touch_edge && s.gc[GC_TOUCH_TRIG]);
  c_batt_high: cover property ($rose(battery_switch_out));

endmodule // tac_ctrl

/* pkg/tac_pkg.sv */
package tac_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_HW = 8'h00;
  localparam logic [7:0] OFS_LW = 8'h04;
  localparam logic [7:0] OFS_RR = 8'h08;
  localparam logic [7:0] OFS_IM = 8'h0C;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_GC = 8'h14;
  localparam logic [7:0] OFS_GS = 8'h18;
  localparam logic [7:0] OFS_IS = 8'h1C;
  localparam logic [7:0] OFS_FS = 8'h20;
  localparam logic [7:0] OFS_BHI = 8'h24;
  localparam logic [7:0] OFS_BHI_END = 8'h60;
  localparam logic [7:0] OFS_BLO = 8'h64;
  localparam logic [7:0] OFS_BLO_END = 8'hA0;
  localparam logic [7:0] OFS_IHW = 8'hA4;
  localparam logic [7:0] OFS_ILW = 8'hA8;
  localparam logic [7:0] OFS_MIS = 8'hAC;
  localparam logic [7:0] OFS_IC = 8'hB0;

  // interrupt bit positions, shared by status, mask, masked and clear
  localparam int IRQ_OVR = 0;
  localparam int IRQ_WM = 1;
  localparam int IRQ_EOS = 2;
  localparam int IRQ_TOUCH = 3;
  localparam int IRQ_BO = 4;
  localparam int IRQ_W = 5;
  localparam int IM_GLOBAL = 6;

  // power configuration fields
  localparam int PC_NOC_LO = 0;
  localparam int PC_BATTERY_ENABLE = 4;
  localparam int PC_PWM_LO = 6;
  localparam int PC_CLK_LO = 8;
  localparam int PC_BATTERY_CHANNEL_SEL_LO = 11;
  localparam logic [1:0] PWM_STANDBY = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;

  // general configuration fields
  localparam int GC_SW_START = 0;
  localparam int GC_TOUCH_TRIG = 1;
  localparam int GC_REPEAT = 2;
  localparam int GC_WMK_LO = 3;

  // general status fields
  localparam int GS_STATE_LO = 4;
  localparam int GS_BUSY = 7;
  localparam int GS_TOUCH_RAW = 8;
  localparam int GS_BO_RAW = 9;

  // fifo status fields
  localparam int FS_RP_LO = 0;
  localparam int FS_WP_LO = 4;
  localparam int FS_EMPTY = 8;
  localparam int FS_FULL = 9;
  localparam int FS_CNT_LO = 10;

  // result word fields
  localparam int RR_DATA_LO = 6;

  // timing in converter clock ticks, fifo depth in entries, converter width in bits
  localparam logic [8:0] MEAS_LAST = 9'h00F;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam int ADC_W = 10;

  typedef enum logic [2:0] {
    TAC_IDLE = 3'b000,
    TAC_FETCH = 3'b001,
    TAC_SETTLE = 3'b010,
    TAC_MEASURE = 3'b011,
    TAC_EOS = 3'b100
  } tac_seq_t;

  // high configuration word layout
  typedef struct packed {
    logic [15:0] reserved;
    logic [8:0] settle_cycles;
    logic [3:0] pos_input_sel;
    logic neg_input_sel;
    logic [1:0] pos_ref_sel;
  } tac_hw_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tac_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tac_apb_rsp_t;

  typedef struct packed {
    tac_seq_t st;
    logic pend;
    logic [3:0] idx;
    logic [8:0] cnt;
    logic [7:0] pre;
    tac_hw_t hw;
    logic [31:0] lw;
    logic [31:0] im;
    logic [31:0] pc;
    logic [31:0] gc;
    logic [31:0] ihw;
    logic [31:0] ilw;
    logic [15:0][31:0] bhi;
    logic [15:0][31:0] blo;
    logic [15:0][15:0] fifo;
    logic [3:0] rp;
    logic [3:0] wp;
    logic [4:0] fcnt;
    logic [IRQ_W-1:0] is;
    logic touch_q;
    tac_apb_rsp_t rsp;
    logic batt;
    logic comb;
  } tac_regs_t;

endpackage

/* tb/tac_panel_model.sv */
`timescale 1ns/1ps
module tac_panel_model (
  input wire logic clk,
  input wire logic bo_req,
  input wire logic touch_req,
  output logic [tac_pkg::ADC_W-1:0] conv_result,
  output logic brownout_det,
  output logic touch_detect_irq
);
  // fixed code so the result word is predictable from the bench side
  assign conv_result = 10'h2A5;
  // comparator and pen lines reach the block already synchronised
  always_ff @(posedge clk) begin
    brownout_det <= bo_req;
    touch_detect_irq <= touch_req;
  end
endmodule // tac_panel_model

/* tb/touch_adc_sequencer_irq_ctrl_tb.sv */
`timescale 1ns/1ps
module touch_adc_sequencer_irq_ctrl_tb;
  import tac_pkg::*;
  logic clk, sys_rst, bo_req, touch_req, err;
  tac_apb_req_t apb_req;
  tac_apb_rsp_t apb_rsp;
  logic [ADC_W-1:0] conv_result;
  logic brownout_det, touch_detect_irq, battery_switch_out;
  logic combined_irq, brownout_irq;
  tac_hw_t active_cfg_high;
  logic [31:0] active_cfg_low, q;
  int failures, comparisons;

  tac_ctrl tac_ctrl_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .conv_result(conv_result),
    .brownout_det(brownout_det),
    .touch_detect_irq(touch_detect_irq),
    .active_cfg_high(active_cfg_high),
    .active_cfg_low(active_cfg_low),
    .battery_switch_out(battery_switch_out),
    .combined_irq(combined_irq),
    .brownout_irq(brownout_irq)
  );
  tac_panel_model tac_panel_model_i (
    .clk(clk),
    .bo_req(bo_req),
    .touch_req(touch_req),
    .conv_result(conv_result),
    .brownout_det(brownout_det),
    .touch_detect_irq(touch_detect_irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one setup plus one access phase; answer taken at the pready edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    apb_req = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    #1 apb_req.penable = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    // one idle edge between transfers so psel never toggles in one step
    #1 apb_req = '0;
    @(posedge clk);
    #1;
    if (n >= 16) begin
      failures++;
      $display("CHECK FAILED pready expected 1 seen %b", apb_rsp.pready);
      final_report();
    end
  endtask

  task automatic rdc(string what, logic [7:0] a, logic [31:0] m,
                     logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q & m);
  endtask

  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    rdc("hw reset", OFS_HW, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, OFS_IM, 32'h0000005F);
    rdc("im rw", OFS_IM, 32'h0000007F, 32'h5F);
    apb(1'b1, 8'h60, 32'h0000A5C3);
    rdc("bank hi 15", 8'h60, 32'hFFFF, 32'hA5C3);
    apb(1'b1, 8'hA0, 32'h00000123);
    rdc("bank lo 15", 8'hA0, 32'hFFFF, 32'h0123);
    apb(1'b0, 8'hB4, 32'h0);
    chk("unmapped err", 1, err);
    apb(1'b1, OFS_IM, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_brownout;
    chk("bo off mode", 1, brownout_irq);
    apb(1'b1, OFS_PC, 32'h00000080);
    wait_clk(4);
    apb(1'b1, OFS_IC, 32'h00000010);
    wait_clk(2);
    chk("bo cleared", 0, brownout_irq);
    bo_req = 1'b1;
    wait_clk(4);
    chk("bo line", 1, brownout_irq);
    rdc("bo raw", OFS_GS, 32'h200, 32'h200);
    bo_req = 1'b0;
    wait_clk(4);
    rdc("bo raw low", OFS_GS, 32'h200, 32'h0);
    rdc("bo latched", OFS_IS, 32'h10, 32'h10);
    apb(1'b1, OFS_PC, 32'h000000C0);
    wait_clk(4);
    rdc("bo mode 11", OFS_GS, 32'h200, 32'h200);
    apb(1'b1, OFS_PC, 32'h00000080);
    wait_clk(4);
    apb(1'b1, OFS_IC, 32'h00000010);
    wait_clk(2);
    chk("bo final", 0, brownout_irq);
    $display("test brownout done");
  endtask

  // one measurement, settle 2, input 5; pc sets the battery enable and channel
  task automatic run_seq(logic [31:0] pc, int exp_hi);
    int hi, bad, busy;
    hi = 0;
    bad = 0;
    busy = 0;
    apb(1'b1, OFS_PC, pc);
    wait_clk(4);
    apb(1'b1, OFS_GC, 32'h00000001);
    for (int i = 0; i < 120; i++) begin
      if (active_cfg_high !== 32'h0) begin
        busy++;
        if (active_cfg_low !== 32'h000000C3) bad++;
      end
      if (battery_switch_out === 1'b1) begin
        hi++;
        if (active_cfg_high !== 32'h128) bad++;
      end
      wait_clk(1);
    end
    chk("batt cycles", exp_hi, hi);
    chk("cfg mirror", 0, bad);
    // bank word stands from fetch through the end tick
    chk("seq ticks", 17 + 2 + 1, busy);
  endtask

  task automatic t_seq;
    apb(1'b1, OFS_IM, 32'h00000044);
    apb(1'b1, OFS_BHI, 32'h00000128);
    apb(1'b1, OFS_BLO, 32'h000000C3);
    run_seq(32'h00002890, 19);
    // threshold 0 keeps the watermark level up
    rdc("eos latched", OFS_IS, 32'h1F, 32'h06);
    chk("combined on", 1, combined_irq);
    rdc("result", OFS_RR, 32'hFFFFFFFF, 32'hA940);
    rdc("fifo empty", OFS_FS, 32'h100, 32'h100);
    apb(1'b1, OFS_IM, 32'h00000040);
    wait_clk(2);
    chk("combined masked", 0, combined_irq);
    rdc("eos kept", OFS_IS, 32'h04, 32'h04);
    apb(1'b1, OFS_IC, 32'h00000004);
    run_seq(32'h00007890, 0);
    rdc("result 2", OFS_RR, 32'hFFFF, 32'hA940);
    run_seq(32'h00002880, 0);
    rdc("result 3", OFS_RR, 32'hF, 32'h0);
    apb(1'b1, OFS_IC, 32'h00000004);
    rdc("eos clear", OFS_IS, 32'h04, 32'h0);
    $display("test sequence done");
  endtask

  task automatic t_touch;
    apb(1'b1, OFS_IM, 32'h00000048);
    apb(1'b1, OFS_GC, 32'h00000002);
    touch_req = 1'b1;
    wait_clk(4);
    rdc("touch raw", OFS_GS, 32'h100, 32'h100);
    chk("touch combined", 1, combined_irq);
    wait_clk(80);
    rdc("touch seq", OFS_IS, 32'h0C, 32'h0C);
    rdc("touch result", OFS_RR, 32'hF, 32'h0);
    apb(1'b1, OFS_IC, 32'h0000000C);
    wait_clk(4);
    rdc("touch clear", OFS_IS, 32'h0C, 32'h0);
    touch_req = 1'b0;
    $display("test touch done");
  endtask

  task automatic t_fifo;
    apb(1'b1, OFS_IM, 32'h0);
    apb(1'b1, OFS_PC, 32'h00000080);
    apb(1'b1, OFS_BHI, 32'h00000028);
    apb(1'b1, OFS_GC, 32'h00000015);
    wait_clk(700);
    apb(1'b1, OFS_GC, 32'h00000010);
    wait_clk(60);
    rdc("wm and ovr", OFS_IS, 32'h03, 32'h03);
    rdc("fifo full", OFS_FS, 32'h7E00, 32'h4200);
    rdc("pop", OFS_RR, 32'hFFC0, 32'hA940);
    rdc("ovr cleared", OFS_IS, 32'h01, 32'h0);
    repeat (13) apb(1'b0, OFS_RR, 32'h0);
    rdc("wm at 2", OFS_IS, 32'h02, 32'h02);
    apb(1'b0, OFS_RR, 32'h0);
    rdc("wm below", OFS_IS, 32'h02, 32'h0);
    rdc("count 1", OFS_FS, 32'h7C00, 32'h0400);
    $display("test fifo done");
  endtask

  initial begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    bo_req = 1'b0;
    touch_req = 1'b0;
    apb_req = '0;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    wait_clk(2);
    t_regs();
    t_brownout();
    t_seq();
    t_touch();
    t_fifo();
    final_report();
  end
endmodule // touch_adc_sequencer_irq_ctrl_tb
